/* File: design/i2t_controller.sv */
`timescale 1ns/10ps
module i2t_controller
  import i2t_pkg::*;
#(
  parameter int QTR = I2T_QTR_CYC
) (
  input  logic        clk_sys,
  input  logic        reset,
  i2t_if.ctrl         bus,
  input  logic        cmd_valid,
  input  i2t_op_t     cmd_op,
  input  logic [7:0]  cmd_data,
  input  logic        cmd_ack,
  output logic        cmd_ready,
  output logic        rsp_valid,
  output logic [7:0]  rsp_data,
  output logic        rsp_nack
);

  localparam int CW = (QTR > 1) ? $clog2(QTR) : 1;

  typedef struct packed {
    i2t_cst_t        st;
    logic [1:0]      ph;
    logic [3:0]      bcnt;
    logic [7:0]      sh;
    logic            rd;
    logic            mack;
    logic            scl_oe;
    logic            sda_oe;
    logic [CW-1:0]   cnt;
    logic            rdy;
    logic            rv;
    logic [7:0]      rdat;
    logic            rnack;
  } i2t_ctl_s_t;

  i2t_ctl_s_t s_q;
  i2t_ctl_s_t s_d;
  logic       tick;

  // ----------------------------------------------------------------
  // quarter-period enable and sequencing
  // ----------------------------------------------------------------
  assign tick = (s_q.cnt == CW'(QTR - 1));

  always_comb begin
    s_d     = s_q;
    s_d.rv  = 1'h0;
    s_d.cnt = tick ? '0 : s_q.cnt + CW'(1);
    case (s_q.st)
      I2T_C_IDLE: begin
        if (cmd_valid && s_q.rdy) begin
          s_d.rdy  = 1'h0;
          s_d.ph   = 2'h0;
          s_d.bcnt = 4'h0;
          s_d.sh   = cmd_data;
          s_d.rd   = (cmd_op == I2T_OP_READ);
          s_d.mack = cmd_ack;
          case (cmd_op)
            I2T_OP_START: s_d.st = I2T_C_START;
            I2T_OP_STOP:  s_d.st = I2T_C_STOP;
            default:      s_d.st = I2T_C_BYTE;
          endcase
        end
      end
      I2T_C_START: begin
        if (tick) begin
          s_d.ph = s_q.ph + 2'h1;
          case (s_q.ph)
            2'h0: s_d.sda_oe = 1'h0;
            2'h1: s_d.scl_oe = 1'h0;
            2'h2: s_d.sda_oe = 1'h1;
            default: begin
              s_d.scl_oe = 1'h1;
              s_d.st     = I2T_C_IDLE;
              s_d.rdy    = 1'h1;
            end
          endcase
        end
      end
      I2T_C_STOP: begin
        if (tick) begin
          s_d.ph = s_q.ph + 2'h1;
          case (s_q.ph)
            2'h0: s_d.sda_oe = 1'h1;
            2'h1: s_d.scl_oe = 1'h0;
            2'h2: s_d.sda_oe = 1'h0;
            default: begin
              s_d.st  = I2T_C_IDLE;
              s_d.rdy = 1'h1;
            end
          endcase
        end
      end
      I2T_C_BYTE: begin
        if (tick) begin
          s_d.ph = s_q.ph + 2'h1;
          case (s_q.ph)
            2'h0: begin
              // data changes only while scl is low
              if (s_q.bcnt != I2T_BITS)
                s_d.sda_oe = !s_q.rd && !s_q.sh[7];
              else
                s_d.sda_oe = s_q.rd && s_q.mack;
            end
            2'h1: s_d.scl_oe = 1'h0;
            2'h2: begin
              if (s_q.bcnt != I2T_BITS)
                s_d.sh = {s_q.sh[6:0], bus.sda};
              else
                s_d.rnack = bus.sda;
            end
            default: begin
              s_d.scl_oe = 1'h1;
              if (s_q.bcnt == I2T_BITS) begin
                s_d.st   = I2T_C_IDLE;
                s_d.rdy  = 1'h1;
                s_d.rv   = 1'h1;
                s_d.rdat = s_q.sh;
                s_d.sda_oe = 1'h0;
              end else begin
                s_d.bcnt = s_q.bcnt + 4'h1;
              end
            end
          endcase
        end
      end
      default: s_d.st = I2T_C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      s_q <= '{st: I2T_C_IDLE, rdy: 1'h1, default: '0};
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // lines are only ever pulled low, never driven high
  assign bus.c_scl_o  = 1'h0;
  assign bus.c_sda_o  = 1'h0;
  assign bus.c_scl_oe = s_q.scl_oe;
  assign bus.c_sda_oe = s_q.sda_oe;
  assign cmd_ready    = s_q.rdy;
  assign rsp_valid    = s_q.rv;
  assign rsp_data     = s_q.rdat;
  assign rsp_nack     = s_q.rnack;

endmodule : i2t_controller

/* File: design/i2t_if.sv */
`timescale 1ns/10ps
interface i2t_if;

  logic scl;
  logic sda;
  logic c_scl_o;
  logic c_scl_oe;
  logic c_sda_o;
  logic c_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;

  // ----------------------------------------------------------------
  // open-drain wired-and with pull-ups
  // ----------------------------------------------------------------
  assign scl = !(c_scl_oe && !c_scl_o);
  assign sda = !((c_sda_oe && !c_sda_o) || (t_sda_oe && !t_sda_o));

  modport ctrl (input scl, sda, output c_scl_o, c_scl_oe, c_sda_o, c_sda_oe);
  modport tgt  (input scl, sda, output t_sda_o, t_sda_oe);

endinterface : i2t_if

/* File: design/i2t_pkg.sv */
package i2t_pkg;

  // ----------------------------------------------------------------
  // bus identity and data layout
  // ----------------------------------------------------------------
  localparam logic [6:0] I2T_ADDR7      = 7'h29;
  localparam int         I2T_IDX_W      = 16;
  localparam int         I2T_DAT_W      = 8;
  localparam int         I2T_IDX_BYTES  = 2;
  localparam int         I2T_REG_DEPTH  = 256;
  localparam logic [3:0] I2T_BITS       = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int I2T_CLK_NS        = 10;
  localparam int I2T_SCL_PERIOD_NS = 1000;
  localparam int I2T_SPIKE_NS      = 50;
  // quarter of an scl period, longest time so rounded down
  localparam int I2T_QTR_CYC  = I2T_SCL_PERIOD_NS / (4 * I2T_CLK_NS);
  // spike width to reject, least time so rounded up
  localparam int I2T_SP_CYC   =
    (I2T_SPIKE_NS + I2T_CLK_NS - 1) / I2T_CLK_NS;

  // ----------------------------------------------------------------
  // controller commands and state codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    I2T_OP_START = 2'h0,
    I2T_OP_WRITE = 2'h1,
    I2T_OP_READ  = 2'h2,
    I2T_OP_STOP  = 2'h3
  } i2t_op_t;

  typedef enum logic [5:0] {
    I2T_T_IDLE = 6'h01,
    I2T_T_ADDR = 6'h02,
    I2T_T_RX   = 6'h04,
    I2T_T_ACK  = 6'h08,
    I2T_T_TX   = 6'h10,
    I2T_T_MACK = 6'h20
  } i2t_tst_t;

  typedef enum logic [3:0] {
    I2T_C_IDLE  = 4'h1,
    I2T_C_START = 4'h2,
    I2T_C_BYTE  = 4'h4,
    I2T_C_STOP  = 4'h8
  } i2t_cst_t;

endpackage : i2t_pkg

/* File: design/i2t_target.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - lines only pulled low or released
// - idle bus leaves both lines released
// - controller alone clocks and starts transfers
// - respond only to address byte 0x52/0x53
// - eight-bit bytes, each followed by acknowledge
// - sample on scl rise, data stable high
// - sda fall/rise with scl high: start/stop
// - message ends with stop or repeated start
// - direction bit clear writes, set reads
// - activity ignored until a start arrives
// - acknowledge matching address by pulling sda low
// - latch direction bit for the message
// - write: first two bytes form index
// - shift in data, acknowledge, store at index
// - read: load register, shift out on falls
// - receiver drives acknowledge after each byte; target withholds it past the last register
// - controller ends message: stop or nack
// - index advances by one per data byte
// - bursts continue without resending index
// - select pin resets interface, not registers
// - select pin high holds interface in reset
module i2t_target
  import i2t_pkg::*;
#(
  parameter int REG_DEPTH = I2T_REG_DEPTH,
  parameter int SP_CYC    = I2T_SP_CYC
) (
  input  logic        clk_sys,
  input  logic        reset,
  input  logic        sel_rst,
  i2t_if.tgt          bus,
  input  logic        usr_wr_en,
  input  logic [15:0] usr_wr_index,
  input  logic [7:0]  usr_wr_data,
  input  logic [15:0] usr_rd_index,
  output logic [7:0]  usr_rd_data,
  output logic        wr_pulse,
  output logic [15:0] wr_index,
  output logic [7:0]  wr_data,
  output logic        busy
);

  localparam int AW = (REG_DEPTH > 1) ? $clog2(REG_DEPTH) : 1;
  localparam int FW = (SP_CYC > 1) ? $clog2(SP_CYC + 1) : 1;

  typedef struct packed {
    i2t_tst_t        st;
    logic [1:0]      flt;
    logic [1:0]      prv;
    logic [1:0][FW-1:0] fcnt;
    logic [3:0]      bcnt;
    logic [7:0]      sh;
    logic            rw;
    logic [15:0]     idx;
    logic [1:0]      nidx;
    logic            mack;
    logic            sda_oe;
    logic            wr;
    logic [15:0]     wr_idx;
    logic [7:0]      wr_dat;
    logic [7:0]      usr_rd;
    logic            busy;
  } i2t_tgt_s_t;

  localparam i2t_tgt_s_t RST = '{
    st: I2T_T_IDLE, flt: 2'h3, prv: 2'h3, default: '0};

  i2t_tgt_s_t s_q;
  i2t_tgt_s_t s_d;
  logic [7:0] mem_q [REG_DEPTH];

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // no reset here: the select pin must leave contents alone
  always_ff @(posedge clk_sys) begin
    if (s_q.wr)
      mem_q[s_q.wr_idx[AW-1:0]] <= s_q.wr_dat;
    else if (usr_wr_en && (32'(usr_wr_index) < REG_DEPTH))
      mem_q[usr_wr_index[AW-1:0]] <= usr_wr_data;
  end

  function automatic logic [7:0] rd_at(input logic [15:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (32'(i) < REG_DEPTH)
      v = mem_q[i[AW-1:0]];
    return v;
  endfunction : rd_at

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic ld;
    logic [7:0] nb;
    logic [1:0] raw;
    rise  = 1'h0;
    fall  = 1'h0;
    start = 1'h0;
    stop  = 1'h0;
    ld    = 1'h0;
    nb    = 8'h00;
    raw   = {bus.scl, bus.sda};
    s_d   = s_q;
    s_d.wr     = 1'h0;
    s_d.usr_rd = rd_at(usr_rd_index);
    s_d.prv    = s_q.flt;
    // spike filter: a line must hold its new level to be taken
    for (int i = 0; i < 2; i++) begin
      if (raw[i] == s_q.flt[i]) begin
        s_d.fcnt[i] = '0;
      end else if (s_q.fcnt[i] == FW'(SP_CYC - 1)) begin
        s_d.flt[i]  = raw[i];
        s_d.fcnt[i] = '0;
      end else begin
        s_d.fcnt[i] = s_q.fcnt[i] + FW'(1);
      end
    end
    rise  = s_q.flt[1] && !s_q.prv[1];
    fall  = !s_q.flt[1] && s_q.prv[1];
    start = s_q.flt[1] && s_q.prv[1] && s_q.prv[0] && !s_q.flt[0];
    stop  = s_q.flt[1] && s_q.prv[1] && !s_q.prv[0] && s_q.flt[0];
    if (start) begin
      // repeated start keeps idx
      s_d.st     = I2T_T_ADDR;
      s_d.bcnt   = 4'h0;
      s_d.nidx   = 2'h0;
      s_d.sda_oe = 1'h0;
    end else if (stop) begin
      s_d.st     = I2T_T_IDLE;
      s_d.sda_oe = 1'h0;
    end else begin
      case (s_q.st)
        I2T_T_IDLE: s_d.st = I2T_T_IDLE;
        I2T_T_ADDR, I2T_T_RX: begin
          if (rise && s_q.bcnt != I2T_BITS) begin
            s_d.sh   = {s_q.sh[6:0], s_q.flt[0]};
            s_d.bcnt = s_q.bcnt + 4'h1;
          end else if (fall && s_q.bcnt == I2T_BITS) begin
            s_d.bcnt = 4'h0;
            if (s_q.st == I2T_T_ADDR) begin
              if (s_q.sh[7:1] == I2T_ADDR7) begin
                s_d.rw     = s_q.sh[0];
                s_d.sda_oe = 1'h1;
                s_d.st     = I2T_T_ACK;
              end else begin
                s_d.st = I2T_T_IDLE;
              end
            end else if (s_q.nidx == 2'h0) begin
              s_d.idx[15:8] = s_q.sh;
              s_d.nidx      = 2'h1;
              s_d.sda_oe    = 1'h1;
              s_d.st        = I2T_T_ACK;
            end else if (s_q.nidx == 2'h1) begin
              s_d.idx[7:0] = s_q.sh;
              s_d.nidx     = 2'h2;
              s_d.sda_oe   = 1'h1;
              s_d.st       = I2T_T_ACK;
            end else if (32'(s_q.idx) < REG_DEPTH) begin
              s_d.wr     = 1'h1;
              s_d.wr_idx = s_q.idx;
              s_d.wr_dat = s_q.sh;
              s_d.idx    = s_q.idx + 16'h1;
              s_d.sda_oe = 1'h1;
              s_d.st     = I2T_T_ACK;
            end else begin
              // past the last register: withhold ack to end the burst
              s_d.st = I2T_T_IDLE;
            end
          end
        end
        I2T_T_ACK: begin
          if (fall) begin
            if (s_q.rw) begin
              ld = 1'h1;
            end else begin
              s_d.sda_oe = 1'h0;
              s_d.st     = I2T_T_RX;
            end
          end
        end
        I2T_T_TX: begin
          if (rise) begin
            s_d.bcnt = s_q.bcnt + 4'h1;
          end else if (fall) begin
            if (s_q.bcnt == I2T_BITS) begin
              s_d.sda_oe = 1'h0;
              s_d.st     = I2T_T_MACK;
            end else begin
              s_d.sh     = {s_q.sh[6:0], 1'h0};
              s_d.sda_oe = !s_q.sh[6];
            end
          end
        end
        I2T_T_MACK: begin
          if (rise) begin
            s_d.mack = !s_q.flt[0];
          end else if (fall) begin
            if (s_q.mack)
              ld = 1'h1;
            else
              s_d.st = I2T_T_IDLE;
          end
        end
        default: s_d.st = I2T_T_IDLE;
      endcase
    end
    if (ld) begin
      // parallel load, first bit goes out on this same scl fall
      nb         = rd_at(s_q.idx);
      s_d.sh     = nb;
      s_d.sda_oe = !nb[7];
      s_d.idx    = s_q.idx + 16'h1;
      s_d.bcnt   = 4'h0;
      s_d.st     = I2T_T_TX;
    end
    s_d.busy = (s_d.st != I2T_T_IDLE);
    if (sel_rst) begin
      // only interface state is cleared; storage is untouched
      s_d        = RST;
      s_d.usr_rd = rd_at(usr_rd_index);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      s_q <= RST;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the target never touches scl and only ever pulls sda low
  assign bus.t_sda_o  = 1'h0;
  assign bus.t_sda_oe = s_q.sda_oe;
  assign usr_rd_data  = s_q.usr_rd;
  assign wr_pulse     = s_q.wr;
  assign wr_index     = s_q.wr_idx;
  assign wr_data      = s_q.wr_dat;
  assign busy         = s_q.busy;

endmodule : i2t_target

/* File: testbench/i2t_checker.sv */
`timescale 1ns/10ps
module i2t_checker (
  input logic clk_sys,
  input logic reset,
  input logic scl,
  input logic sda,
  input logic c_scl_o,
  input logic c_sda_o,
  input logic t_sda_o,
  input logic t_sda_oe
);
  // ------
  // bus event tracking
  // ------
  logic       scl_q;
  logic       sda_q;
  logic       in_q;
  logic       first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       rise;
  logic       start;
  logic       stop;

  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;

  // the count wraps at 9 so every byte plus its ack slot returns it to 0
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      in_q    <= 1'b0;
      first_q <= 1'b0;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
    end else begin
      scl_q   <= scl;
      sda_q   <= sda;
      in_q    <= start ? 1'b1 : (stop ? 1'b0 : in_q);
      first_q <= start ? 1'b1 : ((rise && cnt_q == 4'h8) ? 1'b0 : first_q);
      cnt_q   <= start ? 4'h0 :
                 (!rise ? cnt_q : (cnt_q == 4'h8 ? 4'h0 : cnt_q + 4'h1));
      if (rise) begin
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_pins_pull_low: assert property (!c_scl_o && !c_sda_o && !t_sda_o)
    else $error("pin value not low");
  a_idle_released: assert property (!in_q && !start |-> scl && sda)
    else $error("bus not released when idle");
  a_stop_bus_free: assert property (stop |=> sda [*8])
    else $error("sda pulled too soon after stop");
  a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  a_tgt_edge_low: assert property ($changed(t_sda_oe) |-> !scl)
    else $error("target changed sda while scl high");
  a_tgt_in_msg: assert property (t_sda_oe |-> in_q)
    else $error("target drove sda outside a message");
  a_nine_bit_units: assert property (
    (stop || (start && in_q)) |-> cnt_q == 4'h1)
    else $error("message ended inside a byte");
  a_addr_ack: assert property (rise && first_q && cnt_q == 4'h8 |->
    sda == (sh_q[7:1] != 7'h29))
    else $error("address acknowledge wrong");

  cover property (start && in_q);
  cover property (stop);
  cover property (rise && first_q && cnt_q == 4'h8 && !sda);
endmodule : i2t_checker

/* File: testbench/test_i2c_target_register_port.sv */
`timescale 1ns/10ps
module test_i2c_target_register_port;
  import i2t_pkg::*;
  // ------
  // stimulus and model state
  // ------
  logic        clk_sys      = 1'b0;
  logic        reset        = 1'b1;
  logic        sel_rst      = 1'b0;
  logic        cmd_valid    = 1'b0;
  i2t_op_t     cmd_op       = I2T_OP_START;
  logic [7:0]  cmd_data     = 8'h00;
  logic        cmd_ack      = 1'b0;
  logic        usr_wr_en    = 1'b0;
  logic [15:0] usr_wr_index = 16'h0000;
  logic [7:0]  usr_wr_data  = 8'h00;
  logic [15:0] usr_rd_index = 16'h0000;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rsp_nack;
  logic [7:0]  usr_rd_data;
  logic        busy;
  logic        wr_pulse;
  logic [15:0] wr_index;
  logic [7:0]  wr_data;
  logic [7:0]  m [int];
  logic [7:0]  b;
  int          idx;
  int          a;
  int          miscompares  = 0;
  int          checks_done  = 0;
  int          stores       = 0;
  int          exp_stores   = 0;

  always #5 clk_sys = ~clk_sys;

  // every bus store is counted so a stray or missing one is caught
  always @(posedge clk_sys) begin
    if (wr_pulse === 1'b1)
      stores++;
  end

  i2t_if bus_if ();

  i2t_controller #(.QTR(8)) i2t_controller_i (
    .clk_sys(clk_sys), .reset(reset), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));

  i2t_target #(.SP_CYC(5)) i2t_target_i (
    .clk_sys(clk_sys), .reset(reset), .sel_rst(sel_rst), .bus(bus_if),
    .usr_wr_en(usr_wr_en), .usr_wr_index(usr_wr_index),
    .usr_wr_data(usr_wr_data), .usr_rd_index(usr_rd_index),
    .usr_rd_data(usr_rd_data), .wr_pulse(wr_pulse), .wr_index(wr_index),
    .wr_data(wr_data), .busy(busy));

  i2t_checker i2t_checker_i (
    .clk_sys(clk_sys), .reset(reset), .scl(bus_if.scl), .sda(bus_if.sda),
    .c_scl_o(bus_if.c_scl_o), .c_sda_o(bus_if.c_sda_o),
    .t_sda_o(bus_if.t_sda_o), .t_sda_oe(bus_if.t_sda_oe));

  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one bounded count covers both the take and the byte result
  task automatic cmd(input i2t_op_t o, input logic [7:0] d = 8'h00,
                     input logic k = 1'b0);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op    <= o;
    cmd_data  <= d;
    cmd_ack   <= k;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    if (o == I2T_OP_WRITE || o == I2T_OP_READ) begin
      do begin
        @(negedge clk_sys);
        n++;
      end while (rsp_valid !== 1'b1 && n < 1000);
    end
    if (n >= 1000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : cmd

  task automatic wb(input logic [7:0] d, input logic nk);
    cmd(I2T_OP_WRITE, d);
    chk("nack", {7'h00, nk}, {7'h00, rsp_nack});
    chk("echo", d, rsp_data);
  endtask : wb

  task automatic put(input int i, input int n, input logic stp);
    logic [7:0] d;
    cmd(I2T_OP_START);
    wb(8'h52, 1'b0);
    chk("busy", 8'h01, {7'h00, busy});
    wb(i[15:8], 1'b0);
    wb(i[7:0], 1'b0);
    idx = i;
    repeat (n) begin
      d = 8'($urandom);
      wb(d, idx >= I2T_REG_DEPTH);
      if (idx < I2T_REG_DEPTH) begin
        m[idx] = d;
        exp_stores++;
        chk("wr_data", d, wr_data);
        chk("wr_idx_lo", idx[7:0], wr_index[7:0]);
        chk("wr_idx_hi", idx[15:8], wr_index[15:8]);
      end
      idx++;
    end
    if (stp) cmd(I2T_OP_STOP);
  endtask : put

  task automatic get(input int n);
    cmd(I2T_OP_START);
    wb(8'h53, 1'b0);
    for (int k = 0; k < n; k++) begin
      cmd(I2T_OP_READ, 8'h00, k < n - 1);
      chk("rdata", m[idx], rsp_data);
      chk("mack", {7'h00, k == n - 1}, {7'h00, rsp_nack});
      idx++;
    end
    cmd(I2T_OP_STOP);
  endtask : get

  task automatic loc(input int i, input logic [7:0] d);
    @(posedge clk_sys);
    usr_wr_en    <= 1'b1;
    usr_wr_index <= 16'(i);
    usr_wr_data  <= d;
    usr_rd_index <= 16'(i);
    @(posedge clk_sys);
    usr_wr_en <= 1'b0;
    m[i] = d;
    repeat (3) @(negedge clk_sys);
    chk("local", d, usr_rd_data);
  endtask : loc

  initial begin
    void'($urandom(39));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    loc(0, 8'($urandom));
    repeat (2) begin
      a = 1 + ($urandom % 250);
      put(a, 3, 1'b1);
      put(a, 0, 1'b0);
      get(3);
    end
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      if (b[7:1] == 7'h29) b[7] = 1'b1;
      cmd(I2T_OP_START);
      wb(b, 1'b1);
      chk("busy", 8'h00, {7'h00, busy});
      cmd(I2T_OP_STOP);
    end
    put(256 + ($urandom % 256), 1, 1'b1);
    // index must fall back to zero while storage survives
    @(posedge clk_sys);
    sel_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sel_rst <= 1'b0;
    idx = 0;
    get(1);
    repeat (100) @(negedge clk_sys);
    chk("busy", 8'h00, {7'h00, busy});
    chk("stores", 8'(exp_stores), 8'(stores));
    tally_and_finish();
  end
endmodule : test_i2c_target_register_port
